// *** hw/mmee_pkg.sv ***
package mmee_pkg;

    // error kinds reported by the execution pipeline
    typedef enum logic [1:0] {
        MMEE_ERR_ILLEGAL  = 2'h0,
        MMEE_ERR_INC_READ = 2'h1,
        MMEE_ERR_INC_WRIT = 2'h2,
        MMEE_ERR_FETCH_BR = 2'h3
    } mmee_err_kind_t;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        MMEE_ST_IDLE  = 4'h1,
        MMEE_ST_WRITE = 4'h2,
        MMEE_ST_INTR  = 4'h4,
        MMEE_ST_HALT  = 4'h8
    } mmee_state_t;

    // widths
    localparam int MMEE_P_W    = 18;
    localparam int MMEE_RA_W   = 21;
    localparam int MMEE_WORD_W = 60;
    localparam int MMEE_EC_W   = 6;

    // exit word layout
    localparam int MMEE_EC_LSB = 48;
    localparam int MMEE_EC_MSB = 53;
    localparam int MMEE_P_LSB  = 30;
    localparam int MMEE_P_MSB  = 47;

    // exit condition codes
    localparam logic [5:0] MMEE_EC_ILLEGAL = 6'h00;
    localparam logic [5:0] MMEE_EC_RANGE   = 6'h01;

    // register byte offsets
    localparam logic [7:0] MMEE_REG_CTRL   = 8'h00;
    localparam logic [7:0] MMEE_REG_STATUS = 8'h04;
    localparam logic [7:0] MMEE_REG_LASTP  = 8'h08;

    // control and status bit positions
    localparam int MMEE_CTRL_MASK48  = 0;
    localparam int MMEE_CTRL_RESUME  = 1;
    localparam int MMEE_STAT_BIT48   = 0;
    localparam int MMEE_STAT_HALTED  = 1;
    localparam int MMEE_STAT_EC_LSB  = 8;

    // values after reset
    localparam logic MMEE_MASK48_RST = 1'b0;
    localparam logic [31:0] MMEE_RDATA_RST = 32'h0000_0000;

    // error report from the pipeline
    typedef struct packed {
        mmee_err_kind_t kind;
        logic [MMEE_P_W-1:0] p;
    } mmee_err_t;

    // exit word write toward central memory
    typedef struct packed {
        logic [MMEE_RA_W-1:0] addr;
        logic [MMEE_WORD_W-1:0] data;
    } mmee_memwr_t;

endpackage : mmee_pkg

// *** hw/mmee_exit_unit.sv ***
// How it works
// RULE1: responses act only while monitor flag is one
// RULE2: illegal instruction is suppressed completely
// RULE3: illegal exit word holds code 00, its address
// RULE4: illegal exit taken regardless of exit mode
// RULE5: interrupt to virtual state after exit word
// RULE6: halt in virtual state after that interrupt
// RULE7: out-of-range incremental read sets bit 48
// RULE8: exit mode read keeps operand register unchanged
// RULE9: exit mode keeps offending address in register
// RULE10: exit mode read stores code 01 at base
// RULE11: no exit mode read suppressed, execution continues
// RULE12: exit mode write blocked, code 01 stored
// RULE13: out-of-range incremental write sets bit 48
// RULE14: no exit mode write suppressed, execution continues
// RULE15: fetch or branch out of range inhibits, bit 48
// RULE16: fetch or branch exit ignores exit mode
// RULE17: fetch or branch exit stores target, code 01
// RULE18: mask bit selects exit, clear bit ignores
// RULE19: exit word carries six-bit condition code field
// RULE20: memory write completes before interrupt request
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module mmee_exit_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // processor mode and field
    input wire logic monitor_flag,
    input wire logic [mmee_pkg::MMEE_RA_W-1:0] cm_relocation_base,
    // error report from the pipeline
    input wire logic err_valid,
    input wire mmee_pkg::mmee_err_t err_info,
    output logic err_ready,
    // response strobes toward the pipeline
    output logic inhibit_exec,
    output logic inhibit_read,
    output logic inhibit_write,
    output logic keep_operand,
    output logic keep_aor_address,
    output logic continue_exec,
    // exit word write to central memory
    output logic memwr_valid,
    output mmee_pkg::mmee_memwr_t memwr,
    input wire logic memwr_ready,
    // control transfer to native virtual state
    output logic vs_interrupt,
    output logic vs_halted,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // decode of the incoming error

    logic err_take;
    logic is_illegal;
    logic is_rd;
    logic is_wr;
    logic is_fetch;
    logic is_range;
    logic mask48_reg;
    logic take_exit;
    logic [5:0] exit_code;

    always_comb begin
        is_illegal = 1'b0;
        is_rd = 1'b0;
        is_wr = 1'b0;
        is_fetch = 1'b0;
        // one kind per report; every code of the two-bit field is in use
        case (err_info.kind)
            mmee_pkg::MMEE_ERR_ILLEGAL: begin
                is_illegal = 1'b1;
            end
            mmee_pkg::MMEE_ERR_INC_READ: begin
                is_rd = 1'b1;
            end
            mmee_pkg::MMEE_ERR_INC_WRIT: begin
                is_wr = 1'b1;
            end
            mmee_pkg::MMEE_ERR_FETCH_BR: begin
                is_fetch = 1'b1;
            end
            default: begin
                is_illegal = 1'b0;
            end
        endcase
        is_range = is_rd | is_wr | is_fetch;
        // illegal and fetch/branch exits are unconditional
        take_exit = is_illegal | is_fetch // see RULE4 see RULE16
            | ((is_rd | is_wr) & mask48_reg); // see RULE18
        exit_code = is_illegal ? mmee_pkg::MMEE_EC_ILLEGAL // see RULE3
            : mmee_pkg::MMEE_EC_RANGE; // see RULE10 see RULE12 see RULE17
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    mmee_pkg::mmee_state_t state_reg;
    mmee_pkg::mmee_state_t state_next;
    mmee_pkg::mmee_memwr_t memwr_reg;
    mmee_pkg::mmee_memwr_t memwr_next;
    mmee_pkg::mmee_memwr_t exit_word;
    logic [5:0] last_ec_reg;
    logic [5:0] last_ec_next;
    logic [mmee_pkg::MMEE_P_W-1:0] last_p_reg;
    logic [mmee_pkg::MMEE_P_W-1:0] last_p_next;
    logic bit48_reg;
    logic bit48_next;
    logic mask48_next;
    logic resume_req;
    logic bit48_clr;

    // errors are only accepted in monitor mode and while idle
    assign err_ready = (state_reg == mmee_pkg::MMEE_ST_IDLE);
    assign err_take = err_valid & err_ready & monitor_flag; // see RULE1

    // exit word as it will stand at the relocation base
    always_comb begin
        exit_word.addr = cm_relocation_base;
        exit_word.data = '0;
        exit_word.data[mmee_pkg::MMEE_EC_MSB:mmee_pkg::MMEE_EC_LSB] =
            exit_code; // see RULE19
        // program address as reported: offending, following or target
        exit_word.data[mmee_pkg::MMEE_P_MSB:mmee_pkg::MMEE_P_LSB] =
            err_info.p; // see RULE3 see RULE10 see RULE17
    end

    // idle: waiting for an error report
    // write: exit word offered to central memory
    // intr: one-cycle request to the virtual state
    // halt: stopped until software resumes
    always_comb begin
        state_next = state_reg;
        memwr_next = memwr_reg;
        case (state_reg)
            mmee_pkg::MMEE_ST_IDLE: begin
                if (err_take && take_exit) begin
                    memwr_next = exit_word;
                    state_next = mmee_pkg::MMEE_ST_WRITE;
                end
            end
            mmee_pkg::MMEE_ST_WRITE: begin
                // interrupt only once memory has accepted the exit word
                if (memwr_ready) begin
                    state_next = mmee_pkg::MMEE_ST_INTR; // see RULE20
                end
            end
            mmee_pkg::MMEE_ST_INTR: begin
                state_next = mmee_pkg::MMEE_ST_HALT; // see RULE5 see RULE6
            end
            mmee_pkg::MMEE_ST_HALT: begin
                // stays stopped until software restarts the processor
                if (resume_req) begin
                    state_next = mmee_pkg::MMEE_ST_IDLE;
                end
            end
            default: begin
                state_next = mmee_pkg::MMEE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= mmee_pkg::MMEE_ST_IDLE;
            memwr_reg <= '0;
        end else begin
            state_reg <= state_next;
            memwr_reg <= memwr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // exit record kept for software

    always_comb begin
        last_ec_next = last_ec_reg;
        last_p_next = last_p_reg;
        if (err_take && take_exit) begin
            last_ec_next = exit_code;
            last_p_next = err_info.p;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_ec_reg <= 6'h00;
            last_p_reg <= '0;
        end else begin
            last_ec_reg <= last_ec_next;
            last_p_reg <= last_p_next;
        end
    end

    assign memwr_valid = (state_reg == mmee_pkg::MMEE_ST_WRITE);
    assign memwr = memwr_reg;
    assign vs_interrupt = (state_reg == mmee_pkg::MMEE_ST_INTR); // see RULE5
    assign vs_halted = (state_reg == mmee_pkg::MMEE_ST_HALT); // see RULE6

    ////////////////////////////////////////////////////////////////////////////
    // response strobes, valid in the cycle the error is taken

    always_comb begin
        inhibit_exec = 1'b0;
        inhibit_read = 1'b0;
        inhibit_write = 1'b0;
        keep_operand = 1'b0;
        keep_aor_address = 1'b0;
        continue_exec = 1'b0;
        if (err_take) begin
            // everything that faulted is suppressed, exit or not
            case (err_info.kind)
                mmee_pkg::MMEE_ERR_ILLEGAL: begin
                    // nothing of the instruction may reach registers or memory
                    inhibit_exec = 1'b1; // see RULE2
                    inhibit_read = 1'b1; // see RULE2
                    inhibit_write = 1'b1; // see RULE2
                    keep_operand = 1'b1; // see RULE2
                end
                mmee_pkg::MMEE_ERR_INC_READ: begin
                    // exit mode keeps the faulting address for the handler
                    inhibit_read = 1'b1; // see RULE11
                    keep_operand = 1'b1; // see RULE8 see RULE11
                    keep_aor_address = mask48_reg; // see RULE9
                    continue_exec = ~mask48_reg; // see RULE11
                end
                mmee_pkg::MMEE_ERR_INC_WRIT: begin
                    // memory is left untouched with or without exit
                    inhibit_write = 1'b1; // see RULE12 see RULE14
                    keep_aor_address = mask48_reg; // see RULE9
                    continue_exec = ~mask48_reg; // see RULE14
                end
                mmee_pkg::MMEE_ERR_FETCH_BR: begin
                    // target instruction never runs, exit is unconditional
                    inhibit_exec = 1'b1; // see RULE15
                end
                default: begin
                    inhibit_exec = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and status registers

    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ctrl_sel;
    logic stat_sel;
    logic lastp_sel;

    // address decode shared by writes and reads
    always_comb begin
        ctrl_sel = 1'b0;
        stat_sel = 1'b0;
        lastp_sel = 1'b0;
        if (reg_addr == mmee_pkg::MMEE_REG_CTRL) begin
            ctrl_sel = 1'b1;
        end else if (reg_addr == mmee_pkg::MMEE_REG_STATUS) begin
            stat_sel = 1'b1;
        end else if (reg_addr == mmee_pkg::MMEE_REG_LASTP) begin
            lastp_sel = 1'b1;
        end
    end

    // control: exit-mode mask and the resume strobe
    always_comb begin
        resume_req = 1'b0;
        mask48_next = mask48_reg;
        if (reg_wr && ctrl_sel) begin
            mask48_next = reg_wdata[mmee_pkg::MMEE_CTRL_MASK48]; // see RULE18
            // resume is a strobe, it reads back as zero
            resume_req = reg_wdata[mmee_pkg::MMEE_CTRL_RESUME];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask48_reg <= mmee_pkg::MMEE_MASK48_RST;
        end else begin
            mask48_reg <= mask48_next;
        end
    end

    // status: sticky bit 48, a new range error wins over a clear
    always_comb begin
        bit48_clr = reg_wr & stat_sel & reg_wdata[mmee_pkg::MMEE_STAT_BIT48];
        bit48_next = bit48_reg;
        if (err_take && is_range) begin
            bit48_next = 1'b1; // see RULE7 see RULE13 see RULE15
        end else if (bit48_clr) begin
            bit48_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit48_reg <= 1'b0;
        end else begin
            bit48_reg <= bit48_next;
        end
    end

    // readback: data stand for one cycle after the read strobe, else zero
    always_comb begin
        rdata_next = mmee_pkg::MMEE_RDATA_RST;
        if (reg_rd && ctrl_sel) begin
            rdata_next[mmee_pkg::MMEE_CTRL_MASK48] = mask48_reg;
        end else if (reg_rd && stat_sel) begin
            rdata_next[mmee_pkg::MMEE_STAT_BIT48] = bit48_reg;
            rdata_next[mmee_pkg::MMEE_STAT_HALTED] = vs_halted;
            rdata_next[mmee_pkg::MMEE_STAT_EC_LSB +: 6] = last_ec_reg;
        end else if (reg_rd && lastp_sel) begin
            rdata_next[mmee_pkg::MMEE_P_W-1:0] = last_p_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= mmee_pkg::MMEE_RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : mmee_exit_unit

`default_nettype wire

// *** tb/mmee_exit_unit_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmee_exit_unit_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // error side
    input wire logic monitor_flag,
    input wire logic [mmee_pkg::MMEE_RA_W-1:0] cm_relocation_base,
    input wire logic err_valid,
    input wire mmee_pkg::mmee_err_t err_info,
    input wire logic err_ready,
    input wire logic inhibit_exec,
    input wire logic inhibit_read,
    input wire logic inhibit_write,
    input wire logic keep_operand,
    input wire logic keep_aor_address,
    input wire logic continue_exec,
    // exit word and transfer
    input wire logic memwr_valid,
    input wire mmee_pkg::mmee_memwr_t memwr,
    input wire logic memwr_ready,
    input wire logic vs_interrupt,
    input wire logic vs_halted
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire take = err_valid && err_ready && monitor_flag;
    wire [1:0] kd = err_info.kind;
    AST_OFF: assert property (!monitor_flag |-> !(inhibit_exec || inhibit_read || inhibit_write
        || keep_operand || continue_exec)) else $error("strobe outside monitor mode");
    AST_ILLEGAL: assert property (take && kd == 2'h0 |-> inhibit_exec && inhibit_read
        && inhibit_write && keep_operand ##1 memwr_valid
        && memwr.data[53:30] == {6'h00, $past(err_info.p)}) else $error("illegal exit wrong");
    AST_READ: assert property (take && kd == 2'h1 |-> inhibit_read && keep_operand
        && !inhibit_write) else $error("read range response wrong");
    AST_FETCH: assert property (take && kd == 2'h3 |-> inhibit_exec ##1 memwr_valid
        && memwr.data[53:30] == {6'h01, $past(err_info.p)}) else $error("fetch exit wrong");
    AST_NOEXIT: assert property (continue_exec |-> !keep_aor_address ##1 !memwr_valid)
        else $error("exit without mask");
    AST_AORKEEP: assert property (keep_aor_address |=> memwr_valid
        && memwr.data[53:48] == 6'h01) else $error("range exit code wrong");
    AST_BASE: assert property ($rose(memwr_valid) |-> memwr.addr == $past(cm_relocation_base))
        else $error("exit word address wrong");
    AST_HOLD: assert property (memwr_valid && !memwr_ready |=> memwr_valid && $stable(memwr))
        else $error("exit word dropped");
    AST_INTR: assert property (memwr_valid && memwr_ready |=> vs_interrupt && !memwr_valid)
        else $error("interrupt not after write");
    AST_HALT: assert property (vs_interrupt |=> vs_halted && !vs_interrupt && !err_ready)
        else $error("no halt after interrupt");
    cover property (take && keep_aor_address);
    cover property (continue_exec);
    cover property (vs_interrupt ##1 vs_halted);
endmodule : mmee_exit_unit_asserts
////////////////////////////////////////////////////////////////////////////////
bind mmee_exit_unit mmee_exit_unit_asserts mmee_exit_unit_asserts_i (.mclk, .rst,
    .monitor_flag, .cm_relocation_base, .err_valid, .err_info, .err_ready, .inhibit_exec,
    .inhibit_read, .inhibit_write, .keep_operand, .keep_aor_address, .continue_exec,
    .memwr_valid, .memwr, .memwr_ready, .vs_interrupt, .vs_halted);
`default_nettype wire

// *** tb/mmee_exit_unit_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mmee_exit_unit_tb_top;
    logic mclk = 0, rst = 1, monitor_flag = 1, err_valid = 0, memwr_ready = 0;
    logic reg_wr = 0, reg_rd = 0, err_ready, inhibit_exec, inhibit_read, inhibit_write;
    logic keep_operand, keep_aor_address, continue_exec, memwr_valid, vs_interrupt, vs_halted;
    logic [mmee_pkg::MMEE_RA_W-1:0] cm_relocation_base = '0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    mmee_pkg::mmee_err_t err_info = '0;
    mmee_pkg::mmee_memwr_t memwr;
    int errors = 0, comparisons = 0;
    always #2 mclk = ~mclk;
    mmee_exit_unit mmee_exit_unit_i (.mclk, .rst, .monitor_flag, .cm_relocation_base,
        .err_valid, .err_info, .err_ready, .inhibit_exec, .inhibit_read, .inhibit_write,
        .keep_operand, .keep_aor_address, .continue_exec, .memwr_valid, .memwr, .memwr_ready,
        .vs_interrupt, .vs_halted, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(64'(reg_rdata & m), 64'(e));
    endtask : rd
    // one error report, strobes checked in the take cycle
    task automatic err(input logic [1:0] k, input logic m, input logic [5:0] e);
        @(posedge mclk);
        err_valid <= 1'b1;
        err_info <= {k, m, k, 15'h25A5};
        cm_relocation_base <= {16'hC0DE, 3'h0, k};
        #1 chk(64'({inhibit_exec, inhibit_read, inhibit_write, keep_operand,
            keep_aor_address, continue_exec}), 64'(e));
        @(posedge mclk);
        err_valid <= 1'b0;
    endtask : err
    initial begin
        #100000;
        errors++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h04, 32'hFFFFFFFF, 32'h0);
        rd(8'h10, 32'hFFFFFFFF, 32'h0);
        @(posedge mclk);
        monitor_flag <= 1'b0;
        err(2'h0, 1'b0, 6'h00);
        #1 chk(64'(memwr_valid), 64'h0);
        @(posedge mclk);
        monitor_flag <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 32'(m));
            for (int k = 0; k < 4; k++) begin
                err(2'(k), m[0], {k == 0 || k == 3, k < 2, k == 0 || k == 2, k < 2,
                    (k == 1 || k == 2) && m == 1, (k == 1 || k == 2) && m == 0});
                if (k == 0 || k == 3 || m == 1) begin
                    #1 chk(64'(memwr.data), {6'h0, 6'(k != 0), m[0], 2'(k), 15'h25A5, 30'h0});
                    chk(64'(memwr.addr), 64'({16'hC0DE, 3'h0, 2'(k)}));
                    repeat (2) @(posedge mclk);
                    memwr_ready <= 1'b1;
                    #1 chk(64'({memwr_valid, vs_interrupt}), 64'h2);
                    @(posedge mclk);
                    memwr_ready <= 1'b0;
                    #1 chk(64'({memwr_valid, vs_interrupt}), 64'h1);
                    @(posedge mclk);
                    #1 chk(64'(vs_halted), 64'h1);
                    rd(8'h04, 32'h3F03, {18'h0, 6'(k != 0), 6'h0, 1'b1, k != 0});
                    rd(8'h08, 32'h3FFFF, {14'h0, m[0], 2'(k), 15'h25A5});
                    wr(8'h00, 32'(m) | 32'h2);
                    #1 chk(64'(vs_halted), 64'h0);
                end else begin
                    #1 chk(64'(memwr_valid), 64'h0);
                end
                rd(8'h04, 32'h1, 32'(k != 0));
                wr(8'h04, 32'h1);
            end
        end
        rd(8'h04, 32'h1, 32'h0);
        final_report();
    end
endmodule : mmee_exit_unit_tb_top
`default_nettype wire
